// *** logic/pmmsi_regs.sv ***
// power-management control/status and message-interrupt capability registers
// Behaviour
// - skip-internal-reset flag read-only, default one, loadable
// - flag zero: reset port on D3hot to D0
// - sticky power-event enable gates event messages
// - four-bit data select, read-only eight-bit data
// - power-event status always reads zero
// - bridge extension bits 22, 23 read zero
// - capability identifier 05h in low byte
// - next pointer reads 64h
// - enable zero: no message interrupts
// - enable one: messages allowed, legacy INTx stopped
// - 64-bit address capable bit reads one
// - address bits 31:2 writable, 1:0 zero
// - upper address writable, used when 64-bit capable
`timescale 1ns/10ps
module pmmsi_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sticky_rst_n,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // default loading from serial bus or eeprom
    input wire logic ld_strobe,
    input wire logic ld_skip_rst,
    input wire logic [7:0] ld_pdata,
    // power state and events
    input wire logic [1:0] power_state,
    input wire logic pm_event,
    output logic pme_msg_req,
    output logic port_soft_rst,
    // interrupt source and message write
    input wire logic irq_req,
    output logic intx_assert,
    output logic msi_wr_req,
    input wire logic msi_wr_ack,
    output logic [63:0] msi_wr_addr,
    output logic [31:0] msi_wr_data
);
    logic skip_rst;
    logic pme_en;
    logic [3:0] data_sel;
    logic [7:0] pdata;
    logic msi_en;
    logic [2:0] mme;
    logic [29:0] addr_lo;
    logic [31:0] addr_hi;
    logic [15:0] msg_data;
    logic [1:0] prev_state;
    logic irq_prev;
    pmmsi_pkg::pmmsi_irq_st_t irq_st;

    // merge a byte-enabled write into an old value
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write strobe aimed at one dword
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
            input logic [7:0] ofs);
        return wr && addr == ofs;
    endfunction

    // message address low dword, bits 1:0 always clear
    function automatic logic [31:0] lo_word(input logic [29:0] a);
        return {a, 2'h0};
    endfunction

    // message data dword, upper half reserved
    function automatic logic [31:0] dat_word(input logic [15:0] d);
        return {16'h0000, d};
    endfunction

    logic [31:0] pm_word;
    logic [31:0] cap_word;
    logic [31:0] next_rdata;
    logic [31:0] wm_pm;
    logic [31:0] wm_cap;
    logic [31:0] wm_lo;
    logic [31:0] wm_hi;
    logic [31:0] wm_dat;

    always_comb begin
        pm_word = '0;
        pm_word[pmmsi_pkg::POS_SKIP_RST] = skip_rst;
        pm_word[pmmsi_pkg::POS_PME_EN] = pme_en;
        pm_word[pmmsi_pkg::POS_DSEL_LO +: 4] = data_sel;
        pm_word[pmmsi_pkg::POS_PME_STS] = 1'b0;
        pm_word[pmmsi_pkg::POS_B2B3] = 1'b0;
        pm_word[pmmsi_pkg::POS_BPCC] = 1'b0;
        pm_word[pmmsi_pkg::POS_PDATA_LO +: 8] = pdata;
    end

    // capability header and message control dword
    always_comb begin
        cap_word = '0;
        cap_word[7:0] = pmmsi_pkg::MSI_CAP_ID;
        cap_word[pmmsi_pkg::POS_NEXT_LO +: 8] = pmmsi_pkg::MSI_NEXT_PTR;
        cap_word[pmmsi_pkg::POS_MSI_EN] = msi_en;
        cap_word[pmmsi_pkg::POS_MMC_LO +: 3] = pmmsi_pkg::MSI_MMC;
        cap_word[pmmsi_pkg::POS_MME_LO +: 3] = mme;
        cap_word[pmmsi_pkg::POS_ADDR64] = pmmsi_pkg::ADDR64_CAP;
    end

    always_comb begin
        unique case (cfg_addr)
            pmmsi_pkg::OFS_PM_CSR: next_rdata = pm_word;
            pmmsi_pkg::OFS_MSI_CAP: next_rdata = cap_word;
            pmmsi_pkg::OFS_MSI_ADDR_LO: next_rdata = lo_word(addr_lo);
            pmmsi_pkg::OFS_MSI_ADDR_HI: next_rdata = addr_hi;
            pmmsi_pkg::OFS_MSI_DATA: next_rdata = dat_word(msg_data);
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    assign wm_pm = be_merge(pm_word, cfg_wdata, cfg_be);
    assign wm_cap = be_merge(cap_word, cfg_wdata, cfg_be);
    assign wm_lo = be_merge(lo_word(addr_lo), cfg_wdata, cfg_be);
    assign wm_hi = be_merge(addr_hi, cfg_wdata, cfg_be);
    assign wm_dat = be_merge(dat_word(msg_data), cfg_wdata, cfg_be);

    // read answer: strobe echoed one cycle later
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata <= '0;
        end else if (cfg_rd) begin
            cfg_rdata <= next_rdata;
        end
    end

    // loadable read-only defaults; host writes never reach them
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            skip_rst <= pmmsi_pkg::SKIP_RST_DFLT;
        end else if (ld_strobe) begin
            skip_rst <= ld_skip_rst;
        end
    end

    // data field, same load path
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pdata <= pmmsi_pkg::PDATA_DFLT;
        end else if (ld_strobe) begin
            pdata <= ld_pdata;
        end
    end

    // sticky: survives the ordinary reset, cleared only by sticky reset
    always_ff @(posedge core_clk or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            pme_en <= 1'b0;
        end else if (wr_hit(cfg_wr, cfg_addr, pmmsi_pkg::OFS_PM_CSR)) begin
            pme_en <= wm_pm[pmmsi_pkg::POS_PME_EN];
        end
    end

    // host-writable fields, one block each
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_sel <= '0;
        end else if (wr_hit(cfg_wr, cfg_addr, pmmsi_pkg::OFS_PM_CSR)) begin
            data_sel <= wm_pm[pmmsi_pkg::POS_DSEL_LO +: 4];
        end
    end

    // enable gates message writes and masks the legacy level
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msi_en <= 1'b0;
        end else if (wr_hit(cfg_wr, cfg_addr, pmmsi_pkg::OFS_MSI_CAP)) begin
            msi_en <= wm_cap[pmmsi_pkg::POS_MSI_EN];
        end
    end

    // stored for software only; a single vector is always sent
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mme <= '0;
        end else if (wr_hit(cfg_wr, cfg_addr, pmmsi_pkg::OFS_MSI_CAP)) begin
            mme <= wm_cap[pmmsi_pkg::POS_MME_LO +: 3];
        end
    end

    // message target, low dword aligned
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_lo <= '0;
        end else if (wr_hit(cfg_wr, cfg_addr,
                pmmsi_pkg::OFS_MSI_ADDR_LO)) begin
            addr_lo <= wm_lo[31:2];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_hi <= '0;
        end else if (wr_hit(cfg_wr, cfg_addr,
                pmmsi_pkg::OFS_MSI_ADDR_HI)) begin
            addr_hi <= wm_hi;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_data <= '0;
        end else if (wr_hit(cfg_wr, cfg_addr, pmmsi_pkg::OFS_MSI_DATA)) begin
            msg_data <= wm_dat[15:0];
        end
    end

    // power-state history for the exit detector
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_state <= pmmsi_pkg::PS_D0;
        end else begin
            prev_state <= power_state;
        end
    end

    logic d3_exit;
    assign d3_exit = prev_state == pmmsi_pkg::PS_D3HOT &&
        power_state == pmmsi_pkg::PS_D0;

    // one-cycle internal reset, suppressed by the skip flag
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_soft_rst <= 1'b0;
        end else begin
            port_soft_rst <= d3_exit && !skip_rst;
        end
    end

    // power-event message request, one cycle per event
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pme_msg_req <= 1'b0;
        end else begin
            pme_msg_req <= pm_event && pme_en;
        end
    end

    // request history for the rising-edge detector
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_prev <= 1'b0;
        end else begin
            irq_prev <= irq_req;
        end
    end

    // legacy level only while messages are off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            intx_assert <= 1'b0;
        end else begin
            intx_assert <= irq_req && !msi_en;
        end
    end

    logic msi_fire;
    logic [31:0] next_msi_hi;
    logic [63:0] next_msi_addr;
    logic [31:0] next_msi_data;

    // only a new request met while idle starts a write;
    // edges during a pending write are dropped
    assign msi_fire = irq_st == pmmsi_pkg::PMMSI_IDLE && msi_en &&
        irq_req && !irq_prev;

    // upper half only when 64-bit capable
    assign next_msi_hi = pmmsi_pkg::ADDR64_CAP ? addr_hi : 32'h0000_0000;
    assign next_msi_addr = {next_msi_hi, lo_word(addr_lo)};
    assign next_msi_data = dat_word(msg_data);

    // message sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st <= pmmsi_pkg::PMMSI_IDLE;
        end else begin
            unique case (irq_st)
                pmmsi_pkg::PMMSI_IDLE: begin
                    if (msi_fire) begin
                        irq_st <= pmmsi_pkg::PMMSI_SEND;
                    end
                end
                pmmsi_pkg::PMMSI_SEND: begin
                    if (msi_wr_ack) begin
                        irq_st <= pmmsi_pkg::PMMSI_IDLE;
                    end
                end
                default: irq_st <= pmmsi_pkg::PMMSI_IDLE;
            endcase
        end
    end

    // request held until the completer answers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msi_wr_req <= 1'b0;
        end else if (msi_fire) begin
            msi_wr_req <= 1'b1;
        end else if (msi_wr_ack) begin
            msi_wr_req <= 1'b0;
        end
    end

    // address and data frozen for the whole handshake
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msi_wr_addr <= '0;
            msi_wr_data <= '0;
        end else if (msi_fire) begin
            msi_wr_addr <= next_msi_addr;
            msi_wr_data <= next_msi_data;
        end
    end
endmodule

// *** logic/pmmsi_pkg.sv ***
// constants for the power-management and message-interrupt register bank
package pmmsi_pkg;
    // configuration dword byte addresses
    localparam logic [7:0] OFS_PM_CSR = 8'h44;
    localparam logic [7:0] OFS_MSI_CAP = 8'h4C;
    localparam logic [7:0] OFS_MSI_ADDR_LO = 8'h50;
    localparam logic [7:0] OFS_MSI_ADDR_HI = 8'h54;
    localparam logic [7:0] OFS_MSI_DATA = 8'h58;
    // field positions, dword at 44h
    localparam int POS_SKIP_RST = 3;
    localparam int POS_PME_EN = 8;
    localparam int POS_DSEL_LO = 9;
    localparam int POS_PME_STS = 15;
    localparam int POS_B2B3 = 22;
    localparam int POS_BPCC = 23;
    localparam int POS_PDATA_LO = 24;
    // field positions, dword at 4Ch
    localparam int POS_NEXT_LO = 8;
    localparam int POS_MSI_EN = 16;
    localparam int POS_MMC_LO = 17;
    localparam int POS_MME_LO = 20;
    localparam int POS_ADDR64 = 23;
    // constant field values
    localparam logic [7:0] MSI_CAP_ID = 8'h05;
    localparam logic [7:0] MSI_NEXT_PTR = 8'h64;
    localparam logic [2:0] MSI_MMC = 3'h2;
    localparam logic ADDR64_CAP = 1'b1;
    localparam logic SKIP_RST_DFLT = 1'b1;
    localparam logic [7:0] PDATA_DFLT = 8'h00;
    // power states
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D3HOT = 2'h3;
    typedef enum logic [1:0] {
        PMMSI_IDLE,
        PMMSI_SEND
    } pmmsi_irq_st_t;
endpackage

// *** bench/pmmsi_regs_monitor.sv ***
// port assertions for the power and message-interrupt register bank
`timescale 1ns/10ps
module pmmsi_regs_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // watched ports
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic pm_event,
    input wire logic pme_msg_req,
    input wire logic port_soft_rst,
    input wire logic intx_assert,
    input wire logic msi_wr_req,
    input wire logic msi_wr_ack,
    input wire logic [63:0] msi_wr_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    chk_cap_hdr: assert property (cfg_rd && cfg_addr == 8'h4C |=>
        cfg_rvalid && cfg_rdata[15:0] == 16'h6405) else $error("cap hdr");
    chk_cap_bits: assert property (cfg_rd && cfg_addr == 8'h4C |=>
        cfg_rdata[23] && cfg_rdata[19:17] == 3'h2) else $error("cap bits");
    chk_pm_fixed: assert property (cfg_rd && cfg_addr == 8'h44 |=>
        !cfg_rdata[15] && cfg_rdata[23:22] == 2'h0) else $error("pm bits");
    chk_addr_align: assert property (cfg_rd && cfg_addr == 8'h50 |=>
        cfg_rdata[1:0] == 2'h0) else $error("addr low bits");
    chk_pme_cause: assert property (!pm_event |=> !pme_msg_req)
        else $error("pme without event");
    chk_rst_pulse: assert property (port_soft_rst |=> !port_soft_rst)
        else $error("soft reset too long");
    chk_msi_hold: assert property (msi_wr_req && !msi_wr_ack |=>
        msi_wr_req && $stable(msi_wr_addr)) else $error("msi dropped");
    chk_no_intx: assert property (msi_wr_req |-> !intx_assert)
        else $error("intx with msi");
    cover property (msi_wr_req && msi_wr_ack);
    cover property (pme_msg_req);
    cover property (port_soft_rst);
endmodule
bind pmmsi_regs pmmsi_regs_monitor pmmsi_regs_monitor_inst (.core_clk,
    .arst_n, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rvalid, .pm_event,
    .pme_msg_req, .port_soft_rst, .intx_assert, .msi_wr_req, .msi_wr_ack,
    .msi_wr_addr);

// *** bench/pmmsi_msi_sink.sv ***
// completer for interrupt message writes, programmable wait
`timescale 1ns/10ps
module pmmsi_msi_sink (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // write handshake
    input wire logic msi_wr_req,
    output logic msi_wr_ack,
    input wire logic [3:0] ack_dly
);
    logic [3:0] cnt;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            msi_wr_ack <= 1'b0;
        end else begin
            msi_wr_ack <= 1'b0;
            // no second ack while the design still sees the first
            if (msi_wr_req && !msi_wr_ack) begin
                cnt <= (cnt == ack_dly) ? 4'h0 : cnt + 4'h1;
                msi_wr_ack <= (cnt == ack_dly);
            end
        end
    end
endmodule

// *** bench/pmmsi_regs_tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/10ps
module pmmsi_regs_tb;
    logic core_clk = 0, arst_n = 0, sticky_rst_n = 0, cfg_wr = 0, cfg_rd = 0;
    logic ld_strobe = 0, ld_skip_rst = 0, pm_event = 0, irq_req = 0, skip = 1;
    logic msi_wr_ack, cfg_rvalid, pme_msg_req, port_soft_rst, intx_assert;
    logic msi_wr_req;
    logic [7:0] cfg_addr = 0, ld_pdata = 0, pdat = 0;
    logic [3:0] cfg_be = 0, ack_dly = 0;
    logic [1:0] power_state = 0;
    logic [31:0] cfg_wdata = 0, cfg_rdata, msi_wr_data, seed = 32'h00007E77;
    logic [63:0] msi_wr_addr;
    logic [31:0] shd [6] = '{default: 32'h0};
    logic [31:0] msk [6] = '{32'h00001F00, 32'h0, 32'h00710000, 32'hFFFFFFFC,
        32'hFFFFFFFF, 32'h0000FFFF};
    int n_errors = 0, checks = 0, cyc = 0, hits, hits2;
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    pmmsi_regs pmmsi_regs_inst (.core_clk, .arst_n, .sticky_rst_n, .cfg_wr,
        .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
        .ld_strobe, .ld_skip_rst, .ld_pdata, .power_state, .pm_event,
        .pme_msg_req, .port_soft_rst, .irq_req, .intx_assert, .msi_wr_req,
        .msi_wr_ack, .msi_wr_addr, .msi_wr_data);
    pmmsi_msi_sink pmmsi_msi_sink_inst (.core_clk, .arst_n, .msi_wr_req,
        .msi_wr_ack, .ack_dly);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // read-only part of each dword, index 1 is an unmapped hole
    function automatic logic [31:0] fix(int i);
        return i == 0 ? {pdat, 20'h0, skip, 3'h0} :
            i == 2 ? 32'h00846405 : 32'h0;
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(int i, logic [3:0] be, logic [31:0] d);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk[i];
        @(negedge core_clk);
        cfg_wr = 1;
        cfg_addr = 8'h44 + 8'(i * 4);
        cfg_be = be;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_wr = 0;
        shd[i] = shd[i] & ~bm | d & bm;
    endtask
    task automatic rd(int i);
        @(negedge core_clk);
        cfg_rd = 1;
        cfg_addr = 8'h44 + 8'(i * 4);
        @(negedge core_clk);
        cfg_rd = 0;
        chk("rvalid", 1, cfg_rvalid);
        chk("rdata", shd[i] | fix(i), cfg_rdata);
    endtask
    task automatic stop_test();
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1;
        sticky_rst_n = 1;
        for (int i = 0; i < 6; i++) rd(i);
        repeat (40) begin
            hits = int'(rnd() % 6);
            wr(hits, 4'(rnd()), rnd());
            rd(hits);
        end
        for (int s = 0; s < 2; s++) begin
            skip = s[0];
            pdat = 8'(rnd());
            @(negedge core_clk);
            ld_strobe = 1;
            ld_skip_rst = skip;
            ld_pdata = pdat;
            @(negedge core_clk);
            ld_strobe = 0;
            rd(0);
            power_state = 2'h3;
            repeat (3) @(negedge core_clk);
            power_state = 2'h0;
            hits = 0;
            repeat (4) @(negedge core_clk) hits += int'(port_soft_rst);
            chk("soft_rst", 64'(!skip), hits);
        end
        for (int e = 0; e < 2; e++) begin
            wr(0, 4'h2, 32'(e) << 8);
            pm_event = 1;
            @(negedge core_clk);
            pm_event = 0;
            chk("pme", e, pme_msg_req);
        end
        // ordinary reset mid-run keeps the sticky enable only
        arst_n = 0;
        @(negedge core_clk);
        arst_n = 1;
        skip = 1;
        pdat = 8'h00;
        shd = '{default: 32'h0};
        shd[0][8] = 1'b1;
        for (int i = 0; i < 6; i++) rd(i);
        // enable survives everything but its own sticky reset
        sticky_rst_n = 0;
        @(negedge core_clk);
        sticky_rst_n = 1;
        shd[0][8] = 0;
        rd(0);
        for (int i = 3; i < 6; i++) wr(i, 4'hF, rnd());
        for (int e = 0; e < 4; e++) begin
            ack_dly = 4'(e);
            wr(2, 4'h4, 32'(e > 0) << 16);
            irq_req = 1;
            hits = 0;
            hits2 = 0;
            repeat (8) begin
                @(negedge core_clk);
                hits += int'(msi_wr_req);
                hits2 += int'(intx_assert);
                if (msi_wr_req === 1'b1) begin
                    chk("msi_addr", {shd[4],shd[3]}, msi_wr_addr);
                    chk("msi_data", shd[5], msi_wr_data);
                end
            end
            chk("msi_sent", e > 0, hits > 0);
            chk("intx", e == 0, hits2 > 0);
            irq_req = 0;
            repeat (3) @(negedge core_clk);
        end
        stop_test();
    end
endmodule
